// ---- rtl/eep_pkg.sv ----
// Shared constants for the two-wire serial memory slave
package eep_pkg;
    localparam int ADDR_W = 13;
    localparam int PAGE_LOW_W = 5;
    localparam logic [3:0] DEV_CODE = 4'hA;
    localparam logic [12:0] ADDR_RST = 13'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam int SYNC_STAGES = 3;
    localparam int CLK_MHZ = 100;
    // Internal write cycle time in microseconds, multiplied by CLK_MHZ to give cycles
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int BUF_DEPTH = 2;
endpackage

// ---- rtl/eep_skid_buf.sv ----
// Two-entry valid/ready buffer carrying memory write words
`timescale 1ns/1ps
module eep_skid_buf #(
    parameter int WIDTH = 21
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_ff [2];
    logic [WIDTH-1:0] nxt_mem [2];
    logic wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
    logic [1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_ff != 2'h2);
        out_valid = (cnt_ff != 2'h0);
        out_data = mem_ff[rptr_ff];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_mem = mem_ff;
        nxt_wptr = wptr_ff;
        nxt_rptr = rptr_ff;
        if (push) begin
            nxt_mem[wptr_ff] = in_data;
            nxt_wptr = ~wptr_ff;
        end
        if (pop) begin
            nxt_rptr = ~rptr_ff;
        end
        nxt_cnt = cnt_ff + 2'(push) - 2'(pop);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wptr_ff <= 1'b0;
            rptr_ff <= 1'b0;
            cnt_ff <= 2'h0;
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            cnt_ff <= nxt_cnt;
            mem_ff <= nxt_mem;
        end
    end
endmodule

// ---- rtl/eep_slave.sv ----
// Two-wire serial memory slave: polling, reads, address counter, recovery
//////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module eep_slave
    import eep_pkg::*;
#(
    parameter int WR_CYCLES = WRITE_CYCLES,
    parameter bit SMALL_PART = 1'b0
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic low_supply,
    output logic mem_rd_en,
    output logic [ADDR_W-1:0] mem_rd_addr,
    input wire logic [7:0] mem_rd_data,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [ADDR_W-1:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    output logic write_busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVADR = 3'b001,
        ST_ADRHI = 3'b010,
        ST_ADRLO = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101,
        ST_RACK = 3'b110
    } eep_state_type;

    function automatic logic [ADDR_W-1:0] eep_mask(input logic [ADDR_W-1:0] a);
        // Small part has no top word address bit
        eep_mask = SMALL_PART ? {1'b0, a[ADDR_W-2:0]} : a;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic [SYNC_STAGES-1:0] scl_sync_ff, sda_sync_ff;
    logic scl_ff, sda_ff, nxt_scl, nxt_sda;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        nxt_scl = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_ff;
        nxt_sda = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
        scl_rise = nxt_scl && !scl_ff;
        scl_fall = !nxt_scl && scl_ff;
        start_det = scl_ff && nxt_scl && sda_ff && !nxt_sda;
        stop_det = scl_ff && nxt_scl && !sda_ff && nxt_sda;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            scl_sync_ff <= '1;
            sda_sync_ff <= '1;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[SYNC_STAGES-2:0], scl_in};
            sda_sync_ff <= {sda_sync_ff[SYNC_STAGES-2:0], sda_in};
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Protocol machine
    eep_state_type st_ff, nxt_st;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] shf_ff, nxt_shf;
    logic [ADDR_W-1:0] cnt_ff, nxt_cnt;
    logic [7:0] hi_ff, nxt_hi;
    logic ack_ff, nxt_ack, drv_ff, nxt_drv;
    logic wr_pend_ff, nxt_wr_pend;
    logic [31:0] busy_ff, nxt_busy;
    logic wb_ff, nxt_wb;
    logic rd_en_ff, nxt_rd_en, wr_acc;
    logic [ADDR_W+7:0] buf_out;
    logic buf_ready;
    logic [2:0] strap;

    assign strap = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};

    always_comb begin
        nxt_st = st_ff;
        nxt_bit = bit_ff;
        nxt_shf = shf_ff;
        nxt_cnt = cnt_ff;
        nxt_hi = hi_ff;
        nxt_ack = ack_ff;
        nxt_drv = drv_ff;
        nxt_wr_pend = wr_pend_ff;
        nxt_busy = (busy_ff != 32'h0) ? busy_ff - 32'h1 : 32'h0;
        nxt_rd_en = 1'b0;
        wr_acc = 1'b0;
        if (busy_ff != 32'h0) begin
            nxt_st = ST_IDLE;
            nxt_drv = 1'b0;
            nxt_ack = 1'b0;
        end else if (stop_det) begin
            if (wr_pend_ff && !ack_ff && !low_supply) begin
                nxt_busy = 32'(WR_CYCLES);
            end
            nxt_st = ST_IDLE;
            nxt_drv = 1'b0;
            nxt_ack = 1'b0;
            nxt_wr_pend = 1'b0;
        end else if (start_det) begin
            nxt_st = ST_DEVADR;
            nxt_bit = 4'h0;
            nxt_drv = 1'b0;
            nxt_ack = 1'b0;
            nxt_wr_pend = 1'b0;
        end else if (scl_rise && st_ff != ST_IDLE) begin
            if (ack_ff) begin
                if (st_ff == ST_RACK && nxt_sda) begin
                    nxt_st = ST_IDLE;
                end
            end else begin
                nxt_shf = {shf_ff[6:0], nxt_sda};
                nxt_bit = bit_ff + 4'h1;
            end
        end else if (scl_fall && st_ff != ST_IDLE) begin
            if (ack_ff) begin
                nxt_ack = 1'b0;
                nxt_bit = 4'h0;
                nxt_drv = 1'b0;
                if (st_ff == ST_RACK) begin
                    nxt_st = ST_RDATA;
                    nxt_shf = mem_rd_data;
                    nxt_drv = !mem_rd_data[7];
                end
            end else if (st_ff == ST_RDATA) begin
                if (bit_ff == 4'h8) begin
                    nxt_cnt = eep_mask(cnt_ff + 13'h0001);
                    nxt_rd_en = 1'b1;
                    nxt_st = ST_RACK;
                    nxt_ack = 1'b1;
                    nxt_drv = 1'b0;
                end else begin
                    nxt_drv = !shf_ff[7];
                end
            end else if (bit_ff == 4'h8) begin
                nxt_ack = 1'b1;
                nxt_drv = 1'b1;
                case (st_ff)
                    ST_DEVADR: begin
                        if (shf_ff[7:4] != DEV_CODE || shf_ff[3:1] != strap) begin
                            nxt_st = ST_IDLE;
                            nxt_ack = 1'b0;
                            nxt_drv = 1'b0;
                        end else if (shf_ff[0]) begin
                            nxt_st = ST_RACK;
                            nxt_rd_en = 1'b1;
                        end else begin
                            nxt_st = ST_ADRHI;
                        end
                    end
                    ST_ADRHI: begin
                        nxt_hi = shf_ff;
                        nxt_st = ST_ADRLO;
                    end
                    ST_ADRLO: begin
                        nxt_cnt = eep_mask({hi_ff[4:0], shf_ff});
                        nxt_st = ST_WDATA;
                    end
                    ST_WDATA: begin
                        if (buf_ready) begin
                            wr_acc = 1'b1;
                            nxt_wr_pend = 1'b1;
                            nxt_cnt = {cnt_ff[ADDR_W-1:PAGE_LOW_W],
                                       cnt_ff[PAGE_LOW_W-1:0] + 5'h01};
                        end else begin
                            nxt_ack = 1'b0;
                            nxt_drv = 1'b0;
                            nxt_st = ST_IDLE;
                        end
                    end
                    default: begin
                        nxt_st = ST_IDLE;
                    end
                endcase
            end
        end
        // Busy flag registered so the output comes from a flip-flop
        nxt_wb = (nxt_busy != 32'h0);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff <= ST_IDLE;
            bit_ff <= 4'h0;
            shf_ff <= BYTE_RST;
            cnt_ff <= ADDR_RST;
            hi_ff <= BYTE_RST;
            ack_ff <= 1'b0;
            drv_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            busy_ff <= 32'h0;
            wb_ff <= 1'b0;
            rd_en_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            bit_ff <= nxt_bit;
            shf_ff <= nxt_shf;
            cnt_ff <= nxt_cnt;
            hi_ff <= nxt_hi;
            ack_ff <= nxt_ack;
            drv_ff <= nxt_drv;
            wr_pend_ff <= nxt_wr_pend;
            busy_ff <= nxt_busy;
            wb_ff <= nxt_wb;
            rd_en_ff <= nxt_rd_en;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Write words queue toward the array; a full queue refuses the ack
    logic buf_valid, buf_take, wv_ff, nxt_wv;
    logic [ADDR_W+7:0] wd_ff, nxt_wd;

    eep_skid_buf #(.WIDTH(ADDR_W + 8)) eep_skid_buf_i (
        .mclk(mclk),
        .srst(srst),
        .in_valid(wr_acc),
        .in_ready(buf_ready),
        .in_data({cnt_ff, shf_ff}),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data(buf_out)
    );

    // Output stage refills only when empty or when the array takes its word,
    // so a shown word stays on the outputs until the array takes it
    always_comb begin
        buf_take = !wv_ff || mem_wr_ready;
        nxt_wv = wv_ff;
        nxt_wd = wd_ff;
        if (buf_take) begin
            nxt_wv = buf_valid;
            nxt_wd = buf_out;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wv_ff <= 1'b0;
            wd_ff <= '0;
        end else begin
            wv_ff <= nxt_wv;
            wd_ff <= nxt_wd;
        end
    end

    // Outputs straight from flip-flops, except sda_out which is tied low
    always_comb begin
        sda_out = 1'b0;
        sda_oe = drv_ff;
        mem_rd_en = rd_en_ff;
        mem_rd_addr = cnt_ff;
        mem_wr_valid = wv_ff;
        mem_wr_addr = wd_ff[ADDR_W+7:8];
        mem_wr_data = wd_ff[7:0];
        write_busy = wb_ff;
    end
endmodule

// ---- tb/eep_master.sv ----
// Bit-level two-wire bus master model driving clock and open-drain data
`timescale 1ns/1ps
module eep_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam realtime Q = 31.25;
    // Small skew keeps every link edge off the system clock edges
    localparam realtime E = 0.5;
    // Clock stands high and data released outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic ph(input logic s_low, input logic c);
        #E;
        sda_low = s_low;
        #Q;
        scl = c;
        #(Q - E);
    endtask
    // start: data falls while clock high
    task automatic start();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    // stop: data rises while clock high
    task automatic stop();
        ph(1'b1, 1'b1);
        #E;
        sda_low = 1'b0;
        #(Q - E);
    endtask
    // data changes only with clock low
    task automatic bitx(input logic b, output logic r);
        ph(!b, 1'b1);
        r = sda;
        #(Q + E);
        scl = 1'b0;
        #(Q - E);
    endtask
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    // master acknowledge asks for the next byte
    task automatic byte_r(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(!ack, r);
    endtask
endmodule

// ---- tb/eep_slave_props.sv ----
// Concurrent checks on the serial memory slave ports
`timescale 1ns/1ps
module eep_slave_props
    import eep_pkg::*;
#(
    parameter int WR_CYCLES = 400,
    parameter bit SMALL_PART = 1'b0
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic low_supply,
    input wire logic mem_rd_en,
    input wire logic mem_wr_valid,
    input wire logic mem_wr_ready,
    input wire logic write_busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    property p_busy_mute;
        write_busy |-> !sda_oe && !mem_rd_en;
    endproperty
    a_busy_mute: assert property (p_busy_mute) else $error("bus answered during write cycle");
    property p_busy_len;
        $rose(write_busy) |-> write_busy[*8] ##[1:500] !write_busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    // Counter instead of a long repetition, which the tools cannot unroll
    int busy_cnt;
    always_ff @(posedge mclk) begin
        if (srst) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= write_busy ? busy_cnt + 1 : 0;
        end
    end
    property p_busy_exact;
        $fell(write_busy) |-> busy_cnt == WR_CYCLES;
    endproperty
    a_busy_exact: assert property (p_busy_exact) else $error("write cycle not the set length");
    property p_pull_only;
        sda_oe |-> sda_out == 1'b0;
    endproperty
    a_pull_only: assert property (p_pull_only) else $error("data pin driven high");
    // Data may only move while the clock is low, else it forms a start or stop
    property p_oe_scl_low;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
    property p_rd_pulse;
        mem_rd_en |=> !mem_rd_en;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("fetch request longer than one cycle");
    property p_supply;
        $rose(write_busy) |-> !$past(low_supply);
    endproperty
    a_supply: assert property (p_supply) else $error("write started on low supply");
    property p_wr_hold;
        mem_wr_valid && !mem_wr_ready |=> mem_wr_valid;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write word dropped under stall");
    property p_oe_release;
        $rose(sda_oe) |-> ##[1:200] !sda_oe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("data line held too long");
    c_write: cover property ($rose(write_busy));
    c_stall: cover property (mem_wr_valid && !mem_wr_ready);
    c_fetch: cover property (mem_rd_en);
endmodule

// ---- tb/eep_slave_tb_top.sv ----
// Directed testbench for the serial memory slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module eep_slave_tb_top;
    import eep_pkg::*;
    localparam int WR_CYC = 400;
    localparam logic [6:0] DEV = {DEV_CODE, 3'h5};
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic low_supply = 1'b0;
    logic mem_wr_ready = 1'b0;
    logic scl, sda_low, sda_bus, sda_out, sda_oe, mem_rd_en, mem_wr_valid, write_busy;
    logic [ADDR_W-1:0] mem_rd_addr, mem_wr_addr;
    logic [7:0] mem_rd_data, mem_wr_data;
    logic [20:0] wq[$];
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    function automatic logic [7:0] md(input logic [12:0] a);
        return a[7:0] ^ {3'h0, a[12:8]};
    endfunction
    always #5 mclk = ~mclk;
    assign sda_bus = !(sda_low || sda_oe);
    assign mem_rd_data = md(mem_rd_addr);
    // Array side stalls part of the time so the buffer must hold words
    always @(negedge mclk) begin
        cyc++;
        mem_wr_ready <= (cyc % 16) < 6;
    end
    always @(posedge mclk) if (mem_wr_valid && mem_wr_ready) wq.push_back({mem_wr_addr, mem_wr_data});
    eep_master eep_master_i (.scl(scl), .sda_low(sda_low), .sda(sda_bus));
    eep_slave #(.WR_CYCLES(WR_CYC)) eep_slave_i (.mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(1'b1), .addr_strap_bit1(1'b0),
        .addr_strap_bit2(1'b1), .low_supply(low_supply), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
        .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .write_busy(write_busy));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wbc(input logic [7:0] d, input logic e);
        logic a;
        eep_master_i.byte_w(d, a);
        `CHK("ack", e, a)
    endtask
    task automatic rbc(input logic ack, input logic [7:0] e);
        logic [7:0] d;
        eep_master_i.byte_r(ack, d);
        `CHK("rdata", e, d)
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 2000 && write_busy !== 1'b0; i++) @(negedge mclk);
        if (i == 2000) begin
            err_total++;
            final_report();
        end
    endtask
    // Abandon a read that holds data low, then recover the protocol machine
    task automatic t_recover();
        logic r;
        eep_master_i.start();
        wbc({DEV, 1'b1}, 1'b1);
        for (int i = 0; i < 9; i++) eep_master_i.bitx(1'b1, r);
        eep_master_i.start();
        eep_master_i.stop();
        repeat (4) @(negedge mclk);
        `CHK("oe", 1'b0, sda_oe)
        $display("recover done");
    endtask
    // Page write across the page end, poll while busy, then wait for write_busy to clear
    task automatic t_write();
        eep_master_i.start();
        wbc({DEV, 1'b0}, 1'b1);
        wbc(8'h1F, 1'b1);
        wbc(8'hFF, 1'b1);
        wbc(8'h11, 1'b1);
        wbc(8'h22, 1'b1);
        eep_master_i.stop();
        repeat (8) @(negedge mclk);
        `CHK("busy", 1'b1, write_busy)
        eep_master_i.start();
        wbc({DEV, 1'b1}, 1'b0);
        eep_master_i.stop();
        wait_idle();
        `CHK("word0", {13'h1FFF, 8'h11}, wq[0])
        `CHK("word1", {13'h1FE0, 8'h22}, wq[1])
        eep_master_i.start();
        wbc({DEV, 1'b1}, 1'b1);
        rbc(1'b0, md(13'h1FE1));
        eep_master_i.stop();
        $display("write done");
    endtask
    // Random read with wrap, then a current address read
    task automatic t_read();
        eep_master_i.start();
        wbc({DEV, 1'b0}, 1'b1);
        wbc(8'h1F, 1'b1);
        wbc(8'hFE, 1'b1);
        eep_master_i.start();
        wbc({DEV, 1'b1}, 1'b1);
        rbc(1'b1, md(13'h1FFE));
        rbc(1'b1, md(13'h1FFF));
        rbc(1'b0, md(13'h0000));
        eep_master_i.stop();
        eep_master_i.start();
        wbc({DEV, 1'b1}, 1'b1);
        rbc(1'b0, md(13'h0001));
        eep_master_i.stop();
        $display("read done");
    endtask
    // Wrong strap refused, write cancelled on low supply
    task automatic t_refuse();
        eep_master_i.start();
        wbc({DEV_CODE, 3'h4, 1'b1}, 1'b0);
        eep_master_i.stop();
        @(negedge mclk) low_supply = 1'b1;
        eep_master_i.start();
        wbc({DEV, 1'b0}, 1'b1);
        wbc(8'h00, 1'b1);
        wbc(8'h05, 1'b1);
        wbc(8'h33, 1'b1);
        eep_master_i.stop();
        repeat (8) @(negedge mclk);
        `CHK("busy", 1'b0, write_busy)
        low_supply = 1'b0;
        $display("refuse done");
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        t_recover();
        t_write();
        t_read();
        t_refuse();
        final_report();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        final_report();
    end
endmodule
bind eep_slave eep_slave_props #(.WR_CYCLES(WR_CYCLES), .SMALL_PART(SMALL_PART)) eep_slave_props_i (
    .mclk(mclk), .srst(srst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .low_supply(low_supply),
    .mem_rd_en(mem_rd_en), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .write_busy(write_busy));
